// ===== inc/whs_pkg.sv
// Shared constants for the wake, status and output control block.
// Assumes a single 40 MHz system clock and a host on the 4-wire serial port.
package whs_pkg;
    // Register addresses as seen in the serial command address field.
    localparam logic [4:0] ADDR_OUT_CTRL = 5'h06;
    localparam logic [4:0] ADDR_PWR_CTRL = 5'h07;
    localparam logic [4:0] ADDR_STATUS = 5'h10;

    // Output pin and transmit rate control layout.
    localparam int OUT_SEL_BIT = 7;
    localparam int OUT_VAL_BIT = 6;
    localparam int RATE_MSB = 5;
    localparam logic [7:0] OUT_CTRL_RESET = 8'h14;

    // Output power control layout.
    localparam int PWR_RSVD_BIT = 6;
    localparam int PWR_SEL_BIT = 5;
    localparam int PWR_CODE_MSB = 4;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h50;

    // Status register layout.
    localparam int ST_KEY_BIT = 0;
    localparam int ST_PINWAKE_BIT = 1;
    localparam int ST_RAMLOST_BIT = 2;

    // Serial command types in the three top command bits.
    localparam logic [2:0] CMD_READ_REG = 3'h2;
    localparam logic [2:0] CMD_WRITE_REG = 3'h3;
    localparam logic [2:0] CMD_OFF = 3'h4;
    localparam logic [2:0] CMD_CLEAR_IRQ = 3'h5;

    // Operating mode codes presented by the mode controller.
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_TX = 3'h1;
    localparam logic [2:0] MODE_RX = 3'h2;
    localparam logic [2:0] MODE_RX_POLL = 3'h3;
    localparam logic [2:0] MODE_FULL_DUPLEX = 3'h4;

    // Debounce length in base data clock periods and its counter width.
    localparam int DEBOUNCE_PERIODS = 8195;
    localparam int DEBOUNCE_CNT_W = 14;

    // Synchronised pin indices and their reset levels (select and key idle high).
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_KEY = 3;
    localparam int PIN_LEVEL = 4;
    localparam int PIN_RAMLOW = 5;
    localparam int PIN_DATA_CLK = 6;
    localparam logic [6:0] PIN_RESET = 7'h09;

    // Power state of the digital core.
    typedef enum logic [2:0] {
        PWR_OFF = 3'h1,
        PWR_WAKING = 3'h2,
        PWR_ACTIVE = 3'h4
    } whs_power_e;
endpackage

// ===== inc/whs_debounce_if.sv
// Signals between the control core and the key pin debounce counter.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface whs_debounce_if;
    logic key_level;
    logic base_data_clock_rise;
    logic enable;
    logic running;
    logic done;
    logic stable_level;

    modport ctrl (output key_level, output base_data_clock_rise, output enable,
                  input running, input done, input stable_level);
    modport deb (input key_level, input base_data_clock_rise, input enable,
                 output running, output done, output stable_level);
endinterface

// ===== rtl/whs_key_debounce.sv
// Debounce counter for the key wake pin, counted in base data clock periods.
// Assumes the key level and clock edge arrive already synchronised.
`timescale 1ns/1ps
module whs_key_debounce #(
    parameter int DEBOUNCE_COUNT = whs_pkg::DEBOUNCE_PERIODS
) (
    input wire logic clk,
    input wire logic rst_n,
    whs_debounce_if.deb dbi
);
    localparam logic [whs_pkg::DEBOUNCE_CNT_W-1:0] LAST_COUNT =
        (whs_pkg::DEBOUNCE_CNT_W)'(DEBOUNCE_COUNT - 1);

    typedef struct packed {
        logic run;
        logic [whs_pkg::DEBOUNCE_CNT_W-1:0] cnt;
        logic last;
        logic level;
        logic done;
    } whs_deb_s;

    whs_deb_s st_q;
    whs_deb_s st_d;

    // Outputs come straight from the state flops.
    assign dbi.running = st_q.run;
    assign dbi.done = st_q.done;
    assign dbi.stable_level = st_q.level;

    // A change starts the count when idle and abandons it when one is running.
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (!dbi.enable) begin
            st_d.run = 1'b0;
            st_d.cnt = '0;
            st_d.last = dbi.key_level;
            st_d.level = dbi.key_level;
        end else if (dbi.key_level != st_q.last) begin
            st_d.last = dbi.key_level;
            st_d.cnt = '0;
            st_d.run = !st_q.run;
        end else if (st_q.run && dbi.base_data_clock_rise) begin
            if (st_q.cnt == LAST_COUNT) begin
                st_d.run = 1'b0;
                st_d.done = 1'b1;
                st_d.level = dbi.key_level;
            end else begin
                st_d.cnt = st_q.cnt + 1'b1;
            end
        end
    end

    // State register; the key idles high because of its pull-up.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{run: 1'b0, cnt: '0, last: 1'b1, level: 1'b1, done: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ===== rtl/whs_wake_status_ctrl.sv
// Wake, status and output control logic with its 4-wire serial register port.
// Assumes a 40 MHz SYS_CLK, an active low chip select and serial clock mode 0.
`timescale 1ns/1ps
module whs_wake_status_ctrl #(
    parameter int DEBOUNCE_COUNT = whs_pkg::DEBOUNCE_PERIODS
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE,
    input wire logic KEY_WAKE_PIN,
    input wire logic LEVEL_WAKE_PIN,
    input wire logic RAM_SUPPLY_LOW,
    input wire logic BASE_DATA_CLOCK,
    input wire logic [2:0] OP_MODE,
    input wire logic SUPPLY_READY,
    input wire logic EXT_DATA_TICK,
    output logic GENERAL_OUTPUT_PIN,
    output logic IRQ_OUT,
    output logic CLOCK_OUT_FORCE,
    output logic POWER_ENABLE,
    output logic POWER_RES_FIXED,
    output logic [4:0] POWER_RES_CODE,
    output logic TX_BIT_TICK
);
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] s3;
        logic [6:0] pin;
        logic [6:0] pin_prev;
        whs_pkg::whs_power_e pwr;
        logic wake_by_key;
        logic [7:0] out_ctrl;
        logic [7:0] pwr_ctrl;
        logic key_flag;
        logic pin_wake;
        logic ram_lost;
        logic irq;
        logic clk_hold;
        logic [2:0] bitcnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic have_cmd;
        logic [2:0] cmd;
        logic [4:0] addr;
        logic sdo;
        logic sdo_oe;
        logic [6:0] rate_cnt;
        logic tx_tick;
        logic gp_out;
        logic res_fixed;
        logic clk_force;
        logic pwr_en;
    } whs_top_s;

    whs_top_s st_q;
    whs_top_s st_d;
    logic [1:0] rst_sync_q;
    logic rst_n;

    logic cs_active;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] rx_byte;
    logic byte_done;
    logic cmd_done;
    logic data_done;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    logic load_read;
    logic status_read;
    logic reg_write;
    logic clear_cmd;
    logic off_cmd;
    logic active;
    logic in_tx;
    logic in_rx;
    logic key_fall;
    logic level_rise;
    logic wake_back;
    logic key_wake_ok;
    logic level_wake_ok;
    logic pin_wake_set;
    logic ram_set;
    logic irq_set;
    logic irq_clr;
    logic n_rx_active;

    whs_debounce_if dbif ();

    // Reset is released through two flops so every state flop leaves reset together.
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Outputs come straight from state flops.
    assign SDO = st_q.sdo;
    assign SDO_OE = st_q.sdo_oe;
    assign GENERAL_OUTPUT_PIN = st_q.gp_out;
    assign IRQ_OUT = st_q.irq;
    assign CLOCK_OUT_FORCE = st_q.clk_force;
    assign POWER_ENABLE = st_q.pwr_en;
    assign POWER_RES_FIXED = st_q.res_fixed;
    assign POWER_RES_CODE = st_q.pwr_ctrl[whs_pkg::PWR_CODE_MSB:0];
    assign TX_BIT_TICK = st_q.tx_tick;

    // Serial port decode on the filtered pin levels.
    assign cs_active = !st_q.pin[whs_pkg::PIN_CS];
    assign sck_rise = cs_active && st_q.pin[whs_pkg::PIN_SCK] && !st_q.pin_prev[whs_pkg::PIN_SCK];
    assign sck_fall = cs_active && !st_q.pin[whs_pkg::PIN_SCK] && st_q.pin_prev[whs_pkg::PIN_SCK];
    assign rx_byte = {st_q.rx_sh[6:0], st_q.pin[whs_pkg::PIN_SDI]};
    assign byte_done = sck_rise && (st_q.bitcnt == 3'h7);
    assign cmd_done = byte_done && !st_q.have_cmd;
    assign data_done = byte_done && st_q.have_cmd;

    // Command type sits in the top three bits, the address in the low five.
    assign rd_addr = cmd_done ? rx_byte[4:0] : st_q.addr;
    assign load_read = (cmd_done && rx_byte[7:5] == whs_pkg::CMD_READ_REG)
        || (data_done && st_q.cmd == whs_pkg::CMD_READ_REG);
    assign status_read = load_read && (rd_addr == whs_pkg::ADDR_STATUS);
    assign reg_write = data_done && (st_q.cmd == whs_pkg::CMD_WRITE_REG);
    assign clear_cmd = cmd_done && (rx_byte[7:5] == whs_pkg::CMD_CLEAR_IRQ);
    // Off is refused while either wake pin is asking to stay on.
    assign off_cmd = cmd_done && (rx_byte[7:5] == whs_pkg::CMD_OFF)
        && !st_q.pin[whs_pkg::PIN_LEVEL] && st_q.pin[whs_pkg::PIN_KEY];

    // Register read data; unmapped addresses read as zero.
    always_comb begin
        rd_data = 8'h00;
        case (rd_addr)
            whs_pkg::ADDR_OUT_CTRL: rd_data = st_q.out_ctrl;
            whs_pkg::ADDR_PWR_CTRL: rd_data = st_q.pwr_ctrl;
            whs_pkg::ADDR_STATUS: begin
                rd_data[whs_pkg::ST_KEY_BIT] = st_q.key_flag;
                rd_data[whs_pkg::ST_PINWAKE_BIT] = st_q.pin_wake;
                rd_data[whs_pkg::ST_RAMLOST_BIT] = st_q.ram_lost;
            end
            default: rd_data = 8'h00;
        endcase
    end

    // Mode and pin edge decode.
    assign active = (st_q.pwr == whs_pkg::PWR_ACTIVE);
    assign in_tx = active && (OP_MODE == whs_pkg::MODE_TX);
    assign in_rx = active && (OP_MODE == whs_pkg::MODE_RX || OP_MODE == whs_pkg::MODE_RX_POLL);
    assign n_rx_active = !in_rx;
    assign key_fall = st_q.pin_prev[whs_pkg::PIN_KEY] && !st_q.pin[whs_pkg::PIN_KEY];
    assign level_rise = !st_q.pin_prev[whs_pkg::PIN_LEVEL] && st_q.pin[whs_pkg::PIN_LEVEL];

    // Wake completes only if the waking pin still holds its wake level.
    assign wake_back = st_q.wake_by_key ? st_q.pin[whs_pkg::PIN_KEY]
                                        : !st_q.pin[whs_pkg::PIN_LEVEL];
    assign key_wake_ok = (st_q.pwr == whs_pkg::PWR_WAKING) && SUPPLY_READY
        && !wake_back && st_q.wake_by_key;
    assign level_wake_ok = (st_q.pwr == whs_pkg::PWR_WAKING) && SUPPLY_READY
        && !wake_back && !st_q.wake_by_key;

    // Event sources for the flags and the interrupt.
    assign pin_wake_set = (active && level_rise) || level_wake_ok;
    assign ram_set = st_q.pin[whs_pkg::PIN_RAMLOW] || key_wake_ok || level_wake_ok;
    assign irq_set = (active && level_rise && !st_q.pin_wake) || level_wake_ok
        || key_wake_ok || dbif.done;
    assign irq_clr = status_read || clear_cmd;

    // Debounce counter hookup; it runs only while the core is active.
    assign dbif.key_level = st_q.pin[whs_pkg::PIN_KEY];
    assign dbif.base_data_clock_rise = st_q.pin[whs_pkg::PIN_DATA_CLK]
        && !st_q.pin_prev[whs_pkg::PIN_DATA_CLK];
    assign dbif.enable = active;

    whs_key_debounce #(
        .DEBOUNCE_COUNT(DEBOUNCE_COUNT)
    ) u_debounce (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .dbi(dbif)
    );

    // Next state of the whole block.
    always_comb begin
        st_d = st_q;

        // Three-flop pin filter; a level counts once the last two stages agree.
        st_d.s1 = {BASE_DATA_CLOCK, RAM_SUPPLY_LOW, LEVEL_WAKE_PIN, KEY_WAKE_PIN, SDI, SCK, CS_N};
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.pin = (st_q.s2 & st_q.s3) | (st_q.pin & (st_q.s2 | st_q.s3));
        st_d.pin_prev = st_q.pin;

        // Power state: wake from off on a pin edge, return to off on command.
        case (st_q.pwr)
            whs_pkg::PWR_OFF: begin
                if (key_fall) begin
                    st_d.pwr = whs_pkg::PWR_WAKING;
                    st_d.wake_by_key = 1'b1;
                end else if (level_rise) begin
                    st_d.pwr = whs_pkg::PWR_WAKING;
                    st_d.wake_by_key = 1'b0;
                end
            end
            whs_pkg::PWR_WAKING: begin
                if (wake_back) begin
                    st_d.pwr = whs_pkg::PWR_OFF;
                end else if (SUPPLY_READY) begin
                    st_d.pwr = whs_pkg::PWR_ACTIVE;
                end
            end
            whs_pkg::PWR_ACTIVE: begin
                if (off_cmd) begin
                    st_d.pwr = whs_pkg::PWR_OFF;
                end
            end
            default: st_d.pwr = whs_pkg::PWR_OFF;
        endcase
        st_d.pwr_en = (st_d.pwr != whs_pkg::PWR_OFF);

        // Sticky flags; every set wins over a clear in the same cycle.
        st_d.pin_wake = pin_wake_set || (st_q.pin_wake && !status_read);
        st_d.ram_lost = ram_set
            || (st_q.ram_lost && !(status_read && !st_q.pin[whs_pkg::PIN_RAMLOW]));
        st_d.irq = irq_set || (st_q.irq && !irq_clr);
        st_d.clk_hold = key_wake_ok || (st_q.clk_hold && !status_read);
        if (key_wake_ok) begin
            st_d.key_flag = 1'b1;
        end else if (dbif.done) begin
            st_d.key_flag = !dbif.stable_level;
        end

        // Clock output is held on by the wake flags and the running debounce.
        st_d.clk_force = st_d.pin_wake || dbif.running || st_d.clk_hold;

        // General output pin source.
        st_d.gp_out = st_q.out_ctrl[whs_pkg::OUT_SEL_BIT] ? n_rx_active
            : st_q.out_ctrl[whs_pkg::OUT_VAL_BIT];

        // Fixed resistor only in transmit with power select clear.
        st_d.res_fixed = in_tx && !st_q.pwr_ctrl[whs_pkg::PWR_SEL_BIT];

        // Transmit bit tick every 2*(field+1) extended clock ticks, transmit mode only.
        st_d.tx_tick = 1'b0;
        if (!in_tx) begin
            st_d.rate_cnt = 7'h00;
        end else if (EXT_DATA_TICK) begin
            if (st_q.rate_cnt == {st_q.out_ctrl[whs_pkg::RATE_MSB:0], 1'b1}) begin
                st_d.rate_cnt = 7'h00;
                st_d.tx_tick = 1'b1;
            end else begin
                st_d.rate_cnt = st_q.rate_cnt + 7'h01;
            end
        end

        // Serial shifter: sample on rising, drive on falling serial clock.
        st_d.sdo_oe = cs_active;
        if (!cs_active) begin
            st_d.bitcnt = 3'h0;
            st_d.have_cmd = 1'b0;
            st_d.tx_sh = 8'h00;
        end else if (sck_rise) begin
            st_d.rx_sh = rx_byte;
            st_d.bitcnt = st_q.bitcnt + 3'h1;
            if (cmd_done) begin
                st_d.have_cmd = 1'b1;
                st_d.cmd = rx_byte[7:5];
                st_d.addr = rx_byte[4:0];
            end
            if (load_read) begin
                st_d.tx_sh = rd_data;
                st_d.addr = rd_addr + 5'h01;
            end
            if (reg_write) begin
                st_d.addr = st_q.addr + 5'h01;
                case (st_q.addr)
                    whs_pkg::ADDR_OUT_CTRL: st_d.out_ctrl = rx_byte;
                    whs_pkg::ADDR_PWR_CTRL: st_d.pwr_ctrl = {1'b0, rx_byte[6:0]};
                    default: st_d.addr = st_q.addr + 5'h01;
                endcase
            end
        end else if (sck_fall) begin
            st_d.sdo = st_q.tx_sh[7];
            st_d.tx_sh = {st_q.tx_sh[6:0], 1'b0};
        end
    end

    // State register for everything above.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.s1 <= whs_pkg::PIN_RESET;
            st_q.s2 <= whs_pkg::PIN_RESET;
            st_q.s3 <= whs_pkg::PIN_RESET;
            st_q.pin <= whs_pkg::PIN_RESET;
            st_q.pin_prev <= whs_pkg::PIN_RESET;
            st_q.pwr <= whs_pkg::PWR_OFF;
            st_q.out_ctrl <= whs_pkg::OUT_CTRL_RESET;
            st_q.pwr_ctrl <= whs_pkg::PWR_CTRL_RESET;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ===== tb/whs_wake_status_ctrl_checker.sv
// Port-level checks for the wake, status and output control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module whs_wake_status_ctrl_checker (
    input logic SYS_CLK,
    input logic RSTN,
    input logic CS_N,
    input logic KEY_WAKE_PIN,
    input logic LEVEL_WAKE_PIN,
    input logic [2:0] OP_MODE,
    input logic SDO_OE,
    input logic IRQ_OUT,
    input logic CLOCK_OUT_FORCE,
    input logic POWER_ENABLE,
    input logic POWER_RES_FIXED,
    input logic [4:0] POWER_RES_CODE,
    input logic TX_BIT_TICK
);
    // Everything runs on the system clock and rests while reset is low.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    a_fixed_tx_only: assert property (POWER_RES_FIXED |-> $past(OP_MODE) == 3'h1)
        else $error("fixed resistor outside transmit mode");
    a_tick_tx_only: assert property (TX_BIT_TICK |-> $past(OP_MODE) == 3'h1)
        else $error("bit tick outside transmit mode");
    a_oe_in_frame: assert property (!CS_N [*8] |-> SDO_OE)
        else $error("data out not enabled in a frame");
    a_code_in_frame: assert property ($changed(POWER_RES_CODE) |-> !$past(CS_N))
        else $error("power code changed outside a frame");
    a_irq_fall_frame: assert property ($fell(IRQ_OUT) |-> !$past(CS_N))
        else $error("interrupt cleared outside a frame");
    a_off_needs_pins: assert property ($fell(POWER_ENABLE) |->
        !$past(LEVEL_WAKE_PIN) && $past(KEY_WAKE_PIN))
        else $error("power dropped while a wake pin was active");
    a_wake_power_on: assert property ($fell(KEY_WAKE_PIN) && !POWER_ENABLE |->
        ##[1:8] POWER_ENABLE)
        else $error("key press did not power up");
    a_force_on_key: assert property ($fell(KEY_WAKE_PIN) && POWER_ENABLE |->
        ##[1:8] CLOCK_OUT_FORCE)
        else $error("clock output not forced while debouncing");

    c_irq: cover property ($rose(IRQ_OUT));
    c_off: cover property ($fell(POWER_ENABLE));
    c_tick: cover property (TX_BIT_TICK);
endmodule

bind whs_wake_status_ctrl whs_wake_status_ctrl_checker u_chk (.SYS_CLK, .RSTN, .CS_N,
    .KEY_WAKE_PIN, .LEVEL_WAKE_PIN, .OP_MODE, .SDO_OE, .IRQ_OUT, .CLOCK_OUT_FORCE,
    .POWER_ENABLE, .POWER_RES_FIXED, .POWER_RES_CODE, .TX_BIT_TICK);

// ===== tb/whs_host_model.sv
// Behavioural host that reaches the registers over the 4-wire serial port.
// Assumes serial clock mode 0; an 8-cycle phase keeps well above the 5-cycle minimum.
`timescale 1ns/1ps
module whs_host_model (
    input logic clk,
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input logic sdo
);
    // Idle with select high and the serial clock still.
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // One byte, MSB first; data moves only while the serial clock is low.
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            repeat (8) @(negedge clk);
            sck = 1'b1;
            rx[i] = sdo;
            repeat (8) @(negedge clk);
            sck = 1'b0;
        end
    endtask

    // A frame of a command byte and, when nb is 2, one data byte.
    task automatic xfer(input logic [2:0] cmd, input logic [4:0] adr, input logic [7:0] wd,
        input int nb, output logic [7:0] rd);
        logic [7:0] d;
        d = wd;
        if (cmd == whs_pkg::CMD_WRITE_REG && adr == whs_pkg::ADDR_PWR_CTRL) begin
            d[whs_pkg::PWR_RSVD_BIT] = 1'b1;
        end
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        xbyte({cmd, adr}, rd);
        if (nb == 2) begin
            xbyte(d, rd);
        end
        repeat (8) @(negedge clk);
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ===== tb/whs_wake_status_output_control_bench.sv
// Self-checking bench: registers, wake pins, debounce, output pin and rate.
// Assumes the serial host model and a debounce count shortened to 16.
`timescale 1ns/1ps
module whs_wake_status_output_control_bench;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic key = 1'b1, lvl = 1'b0, ram_low = 1'b0, base_data_clock = 1'b0, rdy = 1'b0, xtick = 1'b0;
    logic [2:0] mode = 3'h0;
    logic cs_n, sck, sdi, sdo, oe, gpo, irq, frc, pwr_en, fix, tick;
    logic [4:0] code;
    logic [7:0] rd;
    int fail_count = 0, n_compared = 0, ph = 0, nt = 0, n0;

    // 40 MHz clock; base data clock of 8 cycles and an extended tick every 4.
    always #12.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        ph <= ph + 1;
        base_data_clock <= ph[2];
        xtick <= (ph[1:0] == 2'h0);
    end
    always @(posedge sys_clk) nt <= nt + int'(tick);

    whs_wake_status_ctrl #(.DEBOUNCE_COUNT(16)) dut (.SYS_CLK(sys_clk), .RSTN(rstn),
        .CS_N(cs_n), .SCK(sck), .SDI(sdi), .SDO(sdo), .SDO_OE(oe), .KEY_WAKE_PIN(key),
        .LEVEL_WAKE_PIN(lvl), .RAM_SUPPLY_LOW(ram_low), .BASE_DATA_CLOCK(base_data_clock),
        .OP_MODE(mode), .SUPPLY_READY(rdy), .EXT_DATA_TICK(xtick),
        .GENERAL_OUTPUT_PIN(gpo), .IRQ_OUT(irq), .CLOCK_OUT_FORCE(frc),
        .POWER_ENABLE(pwr_en), .POWER_RES_FIXED(fix), .POWER_RES_CODE(code),
        .TX_BIT_TICK(tick));
    // A released data line shows the inverse, so a missing enable spoils the read data.
    whs_host_model host (.clk(sys_clk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo(oe ? sdo : ~sdo));

    // Compare and count; an unknown never passes.
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rreg(input logic [4:0] a, input logic [7:0] exp);
        host.xfer(whs_pkg::CMD_READ_REG, a, 8'h00, 2, rd);
        check("register", exp, rd);
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        host.xfer(whs_pkg::CMD_WRITE_REG, a, d, 2, rd);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The tests take about 10,400 cycles; this cuts a hang short.
    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        results();
    end

    // Main sequence; inputs move on the falling edge only.
    initial begin
        cyc(20);
        rstn = 1'b1;
        cyc(8);
        check("pin", 8'h00, gpo);
        check("code", 8'h10, code);
        check("oe", 8'h00, oe);
        rreg(whs_pkg::ADDR_OUT_CTRL, 8'h14);
        rreg(whs_pkg::ADDR_PWR_CTRL, 8'h50);
        rreg(whs_pkg::ADDR_STATUS, 8'h00);
        rreg(5'h1F, 8'h00);
        $display("test reset done");
        key = 1'b0;
        cyc(12);
        check("power", 8'h01, pwr_en);
        key = 1'b1;
        cyc(12);
        check("power", 8'h00, pwr_en);
        check("irq", 8'h00, irq);
        lvl = 1'b1;
        cyc(12);
        rdy = 1'b1;
        cyc(16);
        check("irq", 8'h01, irq);
        check("force", 8'h01, frc);
        rreg(whs_pkg::ADDR_STATUS, 8'h06);
        check("irq", 8'h00, irq);
        ram_low = 1'b1;
        cyc(12);
        rreg(whs_pkg::ADDR_STATUS, 8'h04);
        ram_low = 1'b0;
        cyc(12);
        rreg(whs_pkg::ADDR_STATUS, 8'h04);
        rreg(whs_pkg::ADDR_STATUS, 8'h00);
        lvl = 1'b0;
        cyc(16);
        check("power", 8'h01, pwr_en);
        lvl = 1'b1;
        cyc(16);
        check("irq", 8'h01, irq);
        host.xfer(whs_pkg::CMD_CLEAR_IRQ, 5'h00, 8'h00, 1, rd);
        check("irq", 8'h00, irq);
        lvl = 1'b0;
        cyc(16);
        lvl = 1'b1;
        cyc(16);
        check("irq", 8'h00, irq);
        rreg(whs_pkg::ADDR_STATUS, 8'h02);
        $display("test wake done");
        key = 1'b0;
        cyc(60);
        check("irq", 8'h00, irq);
        check("force", 8'h01, frc);
        cyc(120);
        check("irq", 8'h01, irq);
        rreg(whs_pkg::ADDR_STATUS, 8'h01);
        key = 1'b1;
        cyc(40);
        key = 1'b0;
        cyc(300);
        check("irq", 8'h00, irq);
        key = 1'b1;
        cyc(200);
        check("irq", 8'h01, irq);
        rreg(whs_pkg::ADDR_STATUS, 8'h00);
        $display("test debounce done");
        wreg(whs_pkg::ADDR_OUT_CTRL, 8'h40);
        check("pin", 8'h01, gpo);
        wreg(whs_pkg::ADDR_OUT_CTRL, 8'hC0);
        for (int m = 0; m < 5; m++) begin
            mode = m[2:0];
            cyc(4);
            check("pin", {7'h00, m != 2 && m != 3}, gpo);
        end
        wreg(whs_pkg::ADDR_OUT_CTRL, 8'h0A);
        for (int m = 1; m < 5; m += 3) begin
            mode = (m == 1) ? whs_pkg::MODE_RX : whs_pkg::MODE_FULL_DUPLEX;
            cyc(100);
            n0 = nt;
            cyc(880);
            check("ticks", 8'h00, 8'(nt - n0));
            mode = whs_pkg::MODE_TX;
            cyc(100);
            n0 = nt;
            cyc(880);
            check("ticks", 8'h0A, 8'(nt - n0));
        end
        $display("test output done");
        wreg(whs_pkg::ADDR_PWR_CTRL, 8'h1F);
        rreg(whs_pkg::ADDR_PWR_CTRL, 8'h5F);
        check("code", 8'h1F, code);
        check("fixed", 8'h01, fix);
        mode = whs_pkg::MODE_FULL_DUPLEX;
        cyc(4);
        check("fixed", 8'h00, fix);
        mode = whs_pkg::MODE_TX;
        wreg(whs_pkg::ADDR_PWR_CTRL, 8'h3F);
        check("fixed", 8'h00, fix);
        $display("test power done");
        // Off is refused while the level pin is high, then taken once it is low.
        host.xfer(whs_pkg::CMD_OFF, 5'h00, 8'h00, 1, rd);
        check("power", 8'h01, pwr_en);
        lvl = 1'b0;
        cyc(8);
        host.xfer(whs_pkg::CMD_OFF, 5'h00, 8'h00, 1, rd);
        check("power", 8'h00, pwr_en);
        // A key press with the supply ready completes the wake from off.
        key = 1'b0;
        cyc(40);
        check("irq", 8'h01, irq);
        check("force", 8'h01, frc);
        rreg(whs_pkg::ADDR_STATUS, 8'h05);
        check("force", 8'h00, frc);
        $display("test off and key wake done");
        results();
    end
endmodule
